// ==== inc/dsc_pkg.sv ====
package dsc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CS2 = 8'h04;
  localparam logic [7:0] A_ERR = 8'h08;
  localparam logic [7:0] A_POS = 8'h0c;
  localparam logic [7:0] A_CYL = 8'h10;
  localparam logic [7:0] A_WCNT = 8'h14;
  localparam logic [7:0] A_UADR = 8'h18;
  localparam logic [7:0] A_UDAT = 8'h1c;
  localparam logic [7:0] A_HCRC = 8'h20;
  localparam logic [7:0] A_HFLG = 8'h24;
  localparam logic [7:0] A_IST = 8'h28;
  localparam logic [7:0] A_IMSK = 8'h2c;
  // Value written to control_status_two that clears the controller.
  localparam logic [15:0] CS2_CLEAR = 16'h0020;
  localparam int CS2_UNIT_W = 3;
  // Command register fields.
  localparam int CMD_GO = 0;
  localparam int CMD_FN_LO = 1;
  localparam int CMD_FN_HI = 3;
  localparam int CMD_RDY = 7;
  // Error status bits.
  localparam int E_WP = 0;
  localparam int E_BAD = 1;
  localparam int E_CRC = 2;
  localparam int E_CORR = 3;
  localparam int E_HARD = 4;
  localparam int E_AV = 5;
  localparam int E_WC = 6;
  localparam int E_PGE = 7;
  localparam int NERR = 8;
  // Interrupt status bits.
  localparam int I_DONE = 0;
  localparam int I_ATA = 1;
  localparam int I_IR = 2;
  localparam int NIRQ = 3;
  // Header check word and error-correction limits.
  localparam int HDR_W = 48;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [4:0] ECC_MAX = 5'h0b;
  typedef enum logic [2:0] {
    F_NOP, F_WRITE, F_READ, F_WCHK, F_WHDR, F_RHDR
  } dsc_func_t;
  typedef enum logic [2:0] {
    S_IDLE, S_HDR, S_XFER, S_ECC, S_NEXT, S_DONE
  } dsc_state_t;
endpackage : dsc_pkg

// ==== core/dsc_crc16.sv ====
`timescale 1ns/1ps
module dsc_crc16 import dsc_pkg::*; #(
  parameter int DATA_W = HDR_W
) (
  input wire logic [DATA_W-1:0] data_i,
  output logic [15:0] crc_o
);
  // Bit-serial check word, most significant bit first.
  always_comb begin
    crc_o = CRC_INIT;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (crc_o[15] ^ data_i[i]) begin
        crc_o = {crc_o[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc_o = {crc_o[14:0], 1'b0};
      end
    end
  end
endmodule : dsc_crc16

// ==== core/dsc_core.sv ====
`timescale 1ns/1ps
module dsc_core import dsc_pkg::*; #(
  parameter int SEC_WORDS = 256,
  parameter int SEC_PER_TRK = 32,
  parameter int HEADS = 16,
  parameter int RAM_BYTES = 1024,
  parameter int RA_W = $clog2(RAM_BYTES)
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic [15:0] seek_cyl_o,
  output logic [7:0] seek_head_o,
  output logic [7:0] seek_sec_o,
  input wire logic hdr_valid_i,
  input wire logic [15:0] hdr_cyl_i,
  input wire logic [7:0] hdr_head_i,
  input wire logic [7:0] hdr_sec_i,
  input wire logic hdr_wp_i,
  input wire logic hdr_bad_i,
  input wire logic [15:0] hdr_crc_i,
  output logic hdr_wr_o,
  output logic [15:0] hdr_wr_crc_o,
  output logic [1:0] hdr_wr_flags_o,
  output logic wr_valid_o,
  output logic [15:0] wr_data_o,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  input wire logic ecc_valid_i,
  input wire logic [4:0] ecc_len_i,
  input wire logic [7:0] ecc_pos_i,
  input wire logic [15:0] ecc_pat_i,
  input wire logic dma_we_i,
  input wire logic [RA_W-2:0] dma_addr_i,
  input wire logic [15:0] dma_data_i,
  output logic dma_ready_o
);
  localparam logic [15:0] SW = 16'(SEC_WORDS);
  localparam logic [7:0] SPT = 8'(SEC_PER_TRK);
  localparam logic [7:0] NHD = 8'(HEADS);

  dsc_state_t st;
  dsc_func_t func_r;
  logic go_r, clr_d_r, pready_r, pslverr_r, irq_r, dma_rdy_r;
  logic wr_valid_r, hdr_wr_r;
  logic [31:0] prdata_r;
  logic [15:0] wr_data_r, hcrc_r, hwcrc_r, cyl_r, wcnt_r, rem_r, widx_r;
  logic [7:0] head_r, sec_r;
  logic [1:0] hflag_r;
  logic [CS2_UNIT_W-1:0] unit_r;
  logic [NERR-1:0] err_r, err_set;
  logic [NIRQ-1:0] ist_r, imsk_r, ist_set;
  logic [RA_W-1:0] uadr_r;
  logic [RA_W-2:0] bwa_r, sbase_r, ecc_wa, taken;
  logic [7:0] ram [RAM_BYTES];
  logic access, apb_wr, apb_rd, clr, busy, param_wr, launch;
  logic hv, hdr_match, hdr_stop, ev_av, ev_crc, ev_wp, ev_bad;
  logic ev_hard, ev_corr, ev_wc, rd_store, ecc_fix, is_whdr;
  logic [HDR_W-1:0] hdr_vec;
  logic [15:0] crc_calc;

  function automatic logic [15:0] ram_word(input logic [RA_W-2:0] w);
    return {ram[{w, 1'b1}], ram[{w, 1'b0}]};
  endfunction : ram_word

  // Register read decode; bit 32 of the result marks a mapped offset.
  function automatic logic [32:0] reg_rd(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    if (a == A_CMD) begin
      r[CMD_FN_HI:CMD_FN_LO] = func_r;
      r[CMD_GO] = go_r;
      r[CMD_RDY] = !busy;
    end else if (a == A_CS2) begin
      r[CS2_UNIT_W-1:0] = unit_r;
    end else if (a == A_ERR) begin
      r[NERR-1:0] = err_r;
    end else if (a == A_POS) begin
      r[15:0] = {head_r, sec_r};
    end else if (a == A_CYL) begin
      r[15:0] = cyl_r;
    end else if (a == A_WCNT) begin
      r[15:0] = wcnt_r;
    end else if (a == A_UADR) begin
      r[RA_W-1:0] = uadr_r;
    end else if (a == A_UDAT) begin
      r[7:0] = ram[uadr_r];
    end else if (a == A_HCRC) begin
      r[15:0] = hcrc_r;
    end else if (a == A_HFLG) begin
      r[1:0] = hflag_r;
    end else if (a == A_IST) begin
      r[NIRQ-1:0] = ist_r;
    end else if (a == A_IMSK) begin
      r[NIRQ-1:0] = imsk_r;
    end else begin
      r[32] = 1'b0;
    end
    return r;
  endfunction : reg_rd

  assign access = psel_i & penable_i & pready_r;
  assign apb_wr = access & pwrite_i;
  assign apb_rd = access & !pwrite_i;
  assign clr = apb_wr && paddr_i == A_CS2 && pwdata_i[15:0] == CS2_CLEAR;
  assign busy = (st != S_IDLE) | go_r;
  assign param_wr = apb_wr && (paddr_i == A_CMD || paddr_i == A_POS ||
    paddr_i == A_CYL || paddr_i == A_WCNT || paddr_i == A_HFLG);
  assign launch = apb_wr && paddr_i == A_CMD && !busy && pwdata_i[CMD_GO];
  assign is_whdr = func_r == F_WHDR;

  // Header checks: position compare, check word, protect and bad marks.
  assign hdr_vec = is_whdr ?
    {cyl_r, head_r, sec_r, 14'h0, hflag_r} :
    {hdr_cyl_i, hdr_head_i, hdr_sec_i, 14'h0, hdr_bad_i, hdr_wp_i};
  dsc_crc16 #(.DATA_W(HDR_W)) u_crc (
    .data_i(hdr_vec),
    .crc_o(crc_calc)
  );
  assign hv = st == S_HDR && hdr_valid_i && !is_whdr;
  assign hdr_match = hdr_cyl_i[15:8] == cyl_r[15:8] &&
    hdr_cyl_i[7:0] == cyl_r[7:0] && hdr_head_i == head_r &&
    hdr_sec_i == sec_r;
  assign ev_av = hv && !hdr_match;
  assign ev_crc = hv && crc_calc != hdr_crc_i;
  assign ev_wp = hv && func_r == F_WRITE && hdr_wp_i;
  assign ev_bad = hv && hdr_bad_i && (func_r == F_WRITE ||
    func_r == F_READ || func_r == F_WCHK);
  assign hdr_stop = ev_av | ev_crc | ev_wp | ev_bad;

  assign ev_hard = st == S_ECC && ecc_valid_i && ecc_len_i > ECC_MAX;
  assign ev_corr = st == S_ECC && ecc_valid_i && ecc_len_i != 5'h00 &&
    ecc_len_i <= ECC_MAX;
  assign taken = bwa_r - sbase_r;
  assign ecc_wa = sbase_r + (RA_W-1)'(ecc_pos_i);
  assign ecc_fix = ev_corr && (RA_W-1)'(ecc_pos_i) < taken;
  assign rd_store = st == S_XFER && func_r == F_READ && rd_valid_i &&
    rem_r != 16'h0000;
  assign ev_wc = st == S_XFER && func_r == F_WCHK && rd_valid_i &&
    rem_r != 16'h0000 && rd_data_i != ram_word(bwa_r);

  always_comb begin
    err_set = '0;
    err_set[E_WP] = ev_wp;
    err_set[E_BAD] = ev_bad;
    err_set[E_CRC] = ev_crc;
    err_set[E_CORR] = ev_corr;
    err_set[E_HARD] = ev_hard;
    err_set[E_AV] = ev_av;
    err_set[E_WC] = ev_wc;
    err_set[E_PGE] = param_wr & busy;
  end

  // Errors clear on a controller clear or a new launch; a set wins.
  always_ff @(posedge clk_i or negedge rst_b_i) begin : errors
    if (!rst_b_i) begin
      err_r <= '0;
    end else begin
      err_r <= ((clr | launch) ? '0 : err_r) | err_set;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin : command
    if (!rst_b_i) begin
      go_r <= 1'b0;
      func_r <= F_NOP;
    end else if (clr) begin
      go_r <= 1'b0;
    end else if (launch) begin
      go_r <= 1'b1;
      func_r <= dsc_func_t'(pwdata_i[CMD_FN_HI:CMD_FN_LO]);
    end else if (st == S_DONE) begin
      go_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin : config_regs
    if (!rst_b_i) begin
      wcnt_r <= '0;
      hflag_r <= '0;
      unit_r <= '0;
      imsk_r <= '0;
      uadr_r <= '0;
    end else begin
      if (apb_wr && !busy && paddr_i == A_WCNT) begin
        wcnt_r <= pwdata_i[15:0];
      end
      if (apb_wr && !busy && paddr_i == A_HFLG) begin
        hflag_r <= pwdata_i[1:0];
      end
      if (apb_wr && paddr_i == A_CS2 && !clr) begin
        unit_r <= pwdata_i[CS2_UNIT_W-1:0];
      end
      if (apb_wr && paddr_i == A_IMSK) begin
        imsk_r <= pwdata_i[NIRQ-1:0];
      end
      if (apb_wr && paddr_i == A_UADR) begin
        uadr_r <= pwdata_i[RA_W-1:0];
      end else if (access && paddr_i == A_UDAT) begin
        uadr_r <= uadr_r + 1'b1;
      end
    end
  end

  // Position advances sector, then head, then cylinder.
  always_ff @(posedge clk_i or negedge rst_b_i) begin : position
    if (!rst_b_i) begin
      sec_r <= '0;
      head_r <= '0;
      cyl_r <= '0;
    end else if (st == S_NEXT && rem_r != 16'h0000) begin
      if (sec_r == SPT - 8'h01) begin
        sec_r <= '0;
        if (head_r == NHD - 8'h01) begin
          head_r <= '0;
          cyl_r <= cyl_r + 1'b1;
        end else begin
          head_r <= head_r + 1'b1;
        end
      end else begin
        sec_r <= sec_r + 1'b1;
      end
    end else if (apb_wr && !busy && paddr_i == A_POS) begin
      sec_r <= pwdata_i[7:0];
      head_r <= pwdata_i[15:8];
    end else if (apb_wr && !busy && paddr_i == A_CYL) begin
      cyl_r <= pwdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin : engine
    if (!rst_b_i) begin
      st <= S_IDLE;
      rem_r <= '0;
      widx_r <= '0;
      bwa_r <= '0;
      sbase_r <= '0;
      wr_valid_r <= 1'b0;
      wr_data_r <= '0;
      hdr_wr_r <= 1'b0;
      hwcrc_r <= '0;
      hcrc_r <= '0;
    end else if (clr) begin
      st <= S_IDLE;
      wr_valid_r <= 1'b0;
      hdr_wr_r <= 1'b0;
    end else begin
      wr_valid_r <= 1'b0;
      hdr_wr_r <= 1'b0;
      case (st)
        S_IDLE: begin
          if (go_r) begin
            st <= S_HDR;
            rem_r <= wcnt_r;
            bwa_r <= '0;
          end
        end
        S_HDR: begin
          sbase_r <= bwa_r;
          widx_r <= '0;
          if (is_whdr) begin
            hdr_wr_r <= 1'b1;
            hwcrc_r <= crc_calc;
            st <= S_DONE;
          end else if (hdr_valid_i) begin
            if (func_r == F_RHDR) begin
              hcrc_r <= hdr_crc_i;
            end
            st <= (hdr_stop || func_r == F_RHDR) ? S_DONE : S_XFER;
          end
        end
        S_XFER: begin
          if (func_r == F_WRITE) begin
            if (rem_r != 16'h0000 && widx_r < SW) begin
              wr_valid_r <= 1'b1;
              wr_data_r <= ram_word(bwa_r);
              bwa_r <= bwa_r + 1'b1;
              rem_r <= rem_r - 1'b1;
              widx_r <= widx_r + 1'b1;
            end else begin
              st <= S_NEXT;
            end
          end else if (rd_valid_i) begin
            if (rem_r != 16'h0000) begin
              bwa_r <= bwa_r + 1'b1;
              rem_r <= rem_r - 1'b1;
            end
            widx_r <= widx_r + 1'b1;
            if (widx_r == SW - 16'h0001) begin
              st <= (func_r == F_READ) ? S_ECC : S_NEXT;
            end
          end
        end
        S_ECC: begin
          if (ecc_valid_i) begin
            st <= S_NEXT;
          end
        end
        S_NEXT: begin
          st <= (rem_r == 16'h0000) ? S_DONE : S_HDR;
        end
        S_DONE: begin
          st <= S_IDLE;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // Buffer RAM: engine, then DMA, then host byte port.
  always_ff @(posedge clk_i) begin : buffer_ram
    if (rd_store) begin
      {ram[{bwa_r, 1'b1}], ram[{bwa_r, 1'b0}]} <= rd_data_i;
    end else if (ecc_fix) begin
      {ram[{ecc_wa, 1'b1}], ram[{ecc_wa, 1'b0}]} <=
        ram_word(ecc_wa) ^ ecc_pat_i;
    end else if (dma_we_i && st == S_IDLE) begin
      {ram[{dma_addr_i, 1'b1}], ram[{dma_addr_i, 1'b0}]} <=
        dma_data_i;
    end else if (apb_wr && paddr_i == A_UDAT) begin
      ram[uadr_r] <= pwdata_i[7:0];
    end
  end

  always_comb begin
    ist_set = '0;
    ist_set[I_DONE] = st == S_DONE;
    ist_set[I_ATA] = st == S_DONE && err_r != '0;
    ist_set[I_IR] = clr_d_r;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin : interrupts
    if (!rst_b_i) begin
      clr_d_r <= 1'b0;
      ist_r <= '0;
      irq_r <= 1'b0;
    end else begin
      clr_d_r <= clr;
      if (apb_wr && paddr_i == A_IST) begin
        ist_r <= (ist_r & ~pwdata_i[NIRQ-1:0]) | ist_set;
      end else begin
        ist_r <= ist_r | ist_set;
      end
      irq_r <= |(ist_r & imsk_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin : apb_slave
    if (!rst_b_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      dma_rdy_r <= 1'b0;
    end else begin
      pready_r <= psel_i & !penable_i;
      dma_rdy_r <= st == S_IDLE;
      if (psel_i & !penable_i) begin
        pslverr_r <= !reg_rd(paddr_i)[32];
        prdata_r <= pwrite_i ? 32'h0 : reg_rd(paddr_i)[31:0];
      end else if (apb_rd | apb_wr) begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o = irq_r;
  assign seek_cyl_o = cyl_r;
  assign seek_head_o = head_r;
  assign seek_sec_o = sec_r;
  assign hdr_wr_o = hdr_wr_r;
  assign hdr_wr_crc_o = hwcrc_r;
  assign hdr_wr_flags_o = hflag_r;
  assign wr_valid_o = wr_valid_r;
  assign wr_data_o = wr_data_r;
  assign dma_ready_o = dma_rdy_r;

  property p_wp;
    @(posedge clk_i) disable iff (!rst_b_i)
      ev_wp |=> (err_r[E_WP] && !wr_valid_o)[*2];
  endproperty
  a_wp: assert property (p_wp) else $error("protect not enforced");
  property p_badw;
    @(posedge clk_i) disable iff (!rst_b_i)
      ev_bad && func_r == F_WRITE |=> err_r[E_BAD] && st == S_DONE;
  endproperty
  a_badw: assert property (p_badw) else $error("bad write ran");
  property p_badr;
    @(posedge clk_i) disable iff (!rst_b_i)
      hv && hdr_bad_i && func_r == F_READ |=> err_r[E_BAD] && !rd_store;
  endproperty
  a_badr: assert property (p_badr) else $error("bad read missed");
  property p_crc;
    @(posedge clk_i) disable iff (!rst_b_i)
      hv && func_r == F_RHDR |=> hcrc_r == $past(hdr_crc_i) &&
        err_r[E_CRC] == ($past(crc_calc) != $past(hdr_crc_i));
  endproperty
  a_crc: assert property (p_crc) else $error("check word wrong");
  property p_hard;
    @(posedge clk_i) disable iff (!rst_b_i)
      st == S_ECC && ecc_valid_i && ecc_len_i == 5'h0c |=>
        err_r[E_HARD] && !err_r[E_CORR];
  endproperty
  a_hard: assert property (p_hard) else $error("hard error missed");
  property p_av;
    @(posedge clk_i) disable iff (!rst_b_i)
      ev_av |=> err_r[E_AV] ##1 st == S_IDLE;
  endproperty
  a_av: assert property (p_av) else $error("verify missed");
  property p_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
      clr |=> st == S_IDLE && err_r[E_WP] == 1'b0 ##1 ist_r[I_IR];
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_done;
    @(posedge clk_i) disable iff (!rst_b_i)
      st == S_DONE |=> !go_r && !busy;
  endproperty
  a_done: assert property (p_done) else $error("not ready at end");
  property p_busy;
    @(posedge clk_i) disable iff (!rst_b_i)
      wr_valid_o |-> busy && reg_rd(A_CMD)[CMD_RDY] == 1'b0;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while writing");
  property p_pge;
    @(posedge clk_i) disable iff (!rst_b_i)
      param_wr && st != S_IDLE |=> err_r[E_PGE];
  endproperty
  a_pge: assert property (p_pge) else $error("program error missed");
endmodule : dsc_core

// ==== sim/dsc_disk_model.sv ====
`timescale 1ns/1ps
module dsc_disk_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [49:0] hdr_i,
  input wire logic [15:0] pat_i,
  input wire logic [3:0] nrd_i,
  input wire logic [4:0] ecc_len_i,
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  output logic hdr_valid_o,
  output logic [49:0] hdr_o,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic ecc_valid_o,
  output logic [4:0] ecc_len_o,
  output int wr_cnt_o,
  output logic [15:0] wr_last_o
);
  // Released lines show the inverse of their last value, so a stale bus
  // never passes for fresh data.
  initial begin
    hdr_valid_o = 1'b0;
    rd_valid_o = 1'b0;
    ecc_valid_o = 1'b0;
    hdr_o = '0;
    rd_data_o = 16'h0000;
    ecc_len_o = 5'h00;
    wr_cnt_o = 0;
    wr_last_o = 16'h0000;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        hdr_valid_o <= 1'b1;
        hdr_o <= hdr_i;
        @(posedge clk_i);
        hdr_valid_o <= 1'b0;
        hdr_o <= ~hdr_i;
        if (nrd_i != 4'h0) begin
          repeat (2) @(posedge clk_i);
          for (int i = 0; i < nrd_i; i++) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= pat_i;
            @(posedge clk_i);
          end
          rd_valid_o <= 1'b0;
          rd_data_o <= ~pat_i;
          @(posedge clk_i);
          ecc_valid_o <= 1'b1;
          ecc_len_o <= ecc_len_i;
          @(posedge clk_i);
          ecc_valid_o <= 1'b0;
          ecc_len_o <= ~ecc_len_i;
        end
      end
    end
  end
  always @(posedge clk_i) begin
    if (wr_valid_i === 1'b1) begin
      wr_cnt_o <= wr_cnt_o + 1;
      wr_last_o <= wr_data_i;
    end
  end
endmodule : dsc_disk_model

// ==== sim/dsc_core_bench.sv ====
`timescale 1ns/1ps
module dsc_core_bench import dsc_pkg::*;;
  localparam int SW = 4;
  localparam int SPT = 4;
  logic clk_i = 1'b0, rst_b_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, dma_we_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, irq_o, hdr_wr_o, wr_valid_o, dma_ready_o, perr;
  logic hdr_valid_i, rd_valid_i, ecc_valid_i, dgo = 1'b0;
  logic [15:0] seek_cyl_o, hdr_wr_crc_o, wr_data_o, rd_data_i, wlast;
  logic [15:0] dma_data_i = 16'h0, pat = 16'h0, pc = 16'h0102;
  logic [7:0] seek_head_o, seek_sec_o, ph = 8'h00, ps = 8'h03;
  logic [1:0] hdr_wr_flags_o;
  logic [4:0] ecc_len_i, el = 5'h00;
  logic [8:0] dma_addr_i = 9'h000;
  logic [49:0] hm, hin = '0;
  logic [3:0] nrd = 4'h0;
  int wcnt, miscompares = 0, checks_done = 0, hwn = 0;

  dsc_core #(.SEC_WORDS(SW), .SEC_PER_TRK(SPT), .HEADS(4)) dsc_core_inst (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_o, .seek_cyl_o, .seek_head_o,
    .seek_sec_o, .hdr_valid_i, .hdr_cyl_i(hm[49:34]), .hdr_head_i(hm[33:26]),
    .hdr_sec_i(hm[25:18]), .hdr_wp_i(hm[17]), .hdr_bad_i(hm[16]),
    .hdr_crc_i(hm[15:0]), .hdr_wr_o, .hdr_wr_crc_o, .hdr_wr_flags_o,
    .wr_valid_o, .wr_data_o, .rd_valid_i, .rd_data_i, .ecc_valid_i,
    .ecc_len_i, .ecc_pos_i(8'h00), .ecc_pat_i(16'h00ff), .dma_we_i,
    .dma_addr_i, .dma_data_i, .dma_ready_o);

  dsc_disk_model dsc_disk_model_inst (.clk_i, .go_i(dgo), .hdr_i(hin),
    .pat_i(pat), .nrd_i(nrd), .ecc_len_i(el), .wr_valid_i(wr_valid_o),
    .wr_data_i(wr_data_o), .hdr_valid_o(hdr_valid_i), .hdr_o(hm),
    .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i),
    .ecc_valid_o(ecc_valid_i), .ecc_len_o(ecc_len_i), .wr_cnt_o(wcnt),
    .wr_last_o(wlast));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Counts header write pulses so a missing or doubled pulse shows up.
  always @(posedge clk_i) begin
    if (hdr_wr_o === 1'b1) hwn <= hwn + 1;
  end

  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] crc16(input logic [47:0] v);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc16

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    if (n >= 64) miscompares++;
    q = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic bytes(input logic [31:0] e);
    wr(A_UADR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(A_UDAT);
      chk("ram byte", {24'h0, e[8*i+:8]}, {24'h0, q[7:0]});
    end
  endtask : bytes

  // Sends one header from the disk at the current position, altered by x.
  task automatic fire(input logic [31:0] x, input logic [3:0] fl,
                      input logic [3:0] n);
    logic [31:0] f;
    f = {pc, ph, ps} ^ x;
    hin <= {f, fl[0], fl[1], crc16({f, 14'h0, fl[1], fl[0]}) ^ {16{fl[2]}}};
    nrd <= n;
    dgo <= 1'b1;
    @(posedge clk_i);
    dgo <= 1'b0;
    @(posedge clk_i);
  endtask : fire

  // Flag bits: 0 protect, 1 bad block, 2 corrupt check word, 3 busy poke.
  task automatic op(input logic [2:0] fn, input logic [15:0] wc,
    input int ns, input logic [31:0] x, input logic [3:0] fl,
    input logic [7:0] ee);
    int n;
    wr(A_POS, {16'h0, ph, ps});
    wr(A_CYL, {16'h0, pc});
    wr(A_WCNT, {16'h0, wc});
    wr(A_CMD, {28'h0, fn, 1'b1});
    if (fn != F_WHDR) begin
      rd(A_CMD);
      chk("ready busy", 0, q[CMD_RDY]);
    end
    if (fl[3]) wr(A_POS, 32'h0);
    for (int s = 0; s < ns; s++) begin
      if (s > 0) begin
        if (ps == SPT - 1) begin
          ps = 8'h00;
          ph++;
        end else ps++;
        n = 0;
        while ({seek_head_o, seek_sec_o} !== {ph, ps} && n < 300) begin
          @(posedge clk_i);
          n++;
        end
        chk("next sector", {ph, ps}, {seek_head_o, seek_sec_o});
      end
      if (fn != F_WHDR)
        fire(x, fl, (fn == F_READ || fn == F_WCHK) ? 4'(SW) : 4'h0);
    end
    n = 0;
    do begin
      rd(A_CMD);
      n++;
    end while (q[CMD_RDY] !== 1'b1 && n < 100);
    chk("ready done", 1, q[CMD_RDY]);
    rd(A_ERR);
    chk("error bits", {24'h0, ee}, {24'h0, q[7:0]});
  endtask : op

  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end

  initial begin
    int c0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(A_CMD);
    chk("ready reset", 1, q[CMD_RDY]);
    chk("dma ready", 1, dma_ready_o);
    rd(8'hfc);
    chk("unmapped", 1, perr);
    wr(A_UADR, 32'h0);
    wr(A_UDAT, 32'h34);
    wr(A_UDAT, 32'h12);
    dma_we_i <= 1'b1;
    dma_addr_i <= 9'h001;
    dma_data_i <= 16'hbeef;
    @(posedge clk_i);
    dma_we_i <= 1'b0;
    @(posedge clk_i);
    bytes(32'hbeef1234);
    c0 = wcnt;
    op(F_WRITE, 16'h1, 1, 32'h0, 4'h0, 8'h00);
    chk("words written", 1, wcnt - c0);
    chk("word data", 16'h1234, wlast);
    op(F_WRITE, 16'h1, 1, 32'h0, 4'h1, 8'h01 << E_WP);
    op(F_WRITE, 16'h1, 1, 32'h0, 4'h2, 8'h01 << E_BAD);
    chk("no write", c0 + 1, wcnt);
    op(F_READ, 16'h1, 1, 32'h0, 4'h2, 8'h01 << E_BAD);
    pat <= 16'h5a5a;
    op(F_READ, 16'h1, 1, 32'h0, 4'h0, 8'h00);
    bytes(32'hbeef5a5a);
    op(F_WCHK, 16'h1, 1, 32'h0, 4'h0, 8'h00);
    pat <= 16'h1111;
    op(F_WCHK, 16'h1, 1, 32'h0, 4'h0, 8'h01 << E_WC);
    el <= 5'd11;
    op(F_READ, 16'h1, 1, 32'h0, 4'h0, 8'h01 << E_CORR);
    bytes(32'hbeef11ee);
    el <= 5'd12;
    op(F_READ, 16'h1, 1, 32'h0, 4'h0, 8'h01 << E_HARD);
    el <= 5'd0;
    for (int i = 0; i < 4; i++) begin
      op(F_READ, 16'h1, 1, 32'h1 << (8 * i), 4'h0, 8'h01 << E_AV);
    end
    op(F_RHDR, 16'h0, 1, 32'h0, 4'h4, 8'h01 << E_CRC);
    op(F_RHDR, 16'h0, 1, 32'h0, 4'h0, 8'h00);
    rd(A_HCRC);
    chk("header crc", crc16({pc, ph, ps, 16'h0}), q[15:0]);
    wr(A_HFLG, 32'h1);
    op(F_WHDR, 16'h0, 1, 32'h0, 4'h0, 8'h00);
    chk("header pulse", 1, hwn);
    chk("crc out", crc16({pc, ph, ps, 16'h1}), hdr_wr_crc_o);
    chk("flags out", 2'b01, hdr_wr_flags_o);
    ps = 8'(SPT - 1);
    c0 = wcnt;
    op(F_WRITE, 16'(2 * SW), 2, 32'h0, 4'h0, 8'h00);
    chk("two sectors", 2 * SW, wcnt - c0);
    chk("cylinder", pc, seek_cyl_o);
    op(F_WRITE, 16'h1, 1, 32'h0, 4'h8, 8'h01 << E_PGE);
    rd(A_IST);
    chk("done flag", 1, |q[1:0]);
    chk("irq masked", 0, irq_o);
    rd(A_ERR);
    chk("error held", 8'h01 << E_PGE, q[7:0]);
    wr(A_IST, 32'h7);
    wr(A_CS2, 32'h7);
    wr(A_CS2, {16'h0, CS2_CLEAR});
    wr(A_IMSK, 32'h1 << I_IR);
    rd(A_IST);
    chk("request flag", 1, q[I_IR]);
    chk("irq raised", 1, irq_o);
    rd(A_ERR);
    chk("error cleared", 0, q[7:0]);
    wr(A_IST, 32'h1 << I_IR);
    rd(A_IST);
    chk("irq serviced", 0, irq_o);
    wrap_up;
  end
endmodule : dsc_core_bench
